// file: inc/adc_cfg.svh
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_W          3
`define REG_CTRL        3'h0
`define REG_CFG         3'h1
`define REG_TRIG        3'h2
`define REG_RES_HI      3'h3
`define REG_RES_LO      3'h4

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_EN_BIT     0
`define CTRL_GO_BIT     1
`define CTRL_CHAN_MSB   7
`define CTRL_CHAN_LSB   2
`define CFG_FMT_BIT     7
`define CFG_CLK_MSB     6
`define CFG_CLK_LSB     4
`define CFG_REF_MSB     1
`define CFG_REF_LSB     0
`define TRIG_MSB        3

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define CTRL_RST        8'h00
`define CFG_RST         8'h00
`define TRIG_RST        8'h00
`define RES_RST         8'h00
`define TRIG_OFF        4'h0
`define TRIG_SRC_N      15
`define RES_W           10
`define CHAN_RSV_LO     6'h06
`define CHAN_RSV_HI     6'h0B
`define CLK_RC_A        3'h3
`define CLK_RC_B        3'h7
`define CLK_DIV2        3'h0
`define CLK_DIV8        3'h1
`define CLK_DIV32       3'h2
`define CLK_DIV4        3'h4
`define CLK_DIV16       3'h5
`define CLK_DIV64       3'h6
`define LIM_DIV2        6'h01
`define LIM_DIV4        6'h03
`define LIM_DIV8        6'h07
`define LIM_DIV16       6'h0F
`define LIM_DIV32       6'h1F
`define LIM_DIV64       6'h3F

// ****************************************************************
// Conversion timing in conversion clock ticks
// ****************************************************************
`define CONV_LAST       4'hA

`endif

// file: inc/adc_pkg.sv
package adc_pkg;
  `include "adc_cfg.svh"

  typedef struct packed {
    logic [5:0] chan;
    logic       go;
    logic       en;
    logic       fmt;
    logic [2:0] clk;
    logic [1:0] pref;
    logic [3:0] trig;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [7:0] rdata;
    logic       trig_prev;
    logic       conv_on;
    logic       mux_ok;
    logic       flag;
  } ctrl_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN  = 2'b10
  } seq_mode_t;

  typedef struct packed {
    seq_mode_t              mode;
    logic [3:0]             count;
    logic                   done;
    logic [`RES_W-1:0]      result;
  } seq_state_t;

  typedef struct packed {
    logic [5:0] count;
    logic       rc_meta;
    logic       rc_sync;
    logic       rc_prev;
    logic       tick;
  } div_state_t;

  // Clock select codes that pick the dedicated RC clock
  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel == `CLK_RC_A) || (sel == `CLK_RC_B);
  endfunction

  // Divider terminal count for a system clock code
  function automatic logic [5:0] div_limit(input logic [2:0] sel);
    case (sel)
      `CLK_DIV2:  div_limit = `LIM_DIV2;
      `CLK_DIV4:  div_limit = `LIM_DIV4;
      `CLK_DIV8:  div_limit = `LIM_DIV8;
      `CLK_DIV16: div_limit = `LIM_DIV16;
      `CLK_DIV32: div_limit = `LIM_DIV32;
      `CLK_DIV64: div_limit = `LIM_DIV64;
      default:    div_limit = `LIM_DIV2;
    endcase
  endfunction
endpackage

// file: inc/conv_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg.svh"
interface conv_if;
  logic              run;
  logic              tick;
  logic              done;
  logic [`RES_W-1:0] result;

  modport ctrl (output run, input done, input result);
  modport seq (input run, input tick, output done, output result);
  modport divider (input run, output tick);
endinterface
`default_nettype wire

// file: src/adc_control_registers.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg.svh"
module adc_control_registers
  import adc_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  input  wire logic [`ADDR_W-1:0]      reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic [`TRIG_SRC_N-1:0]  trigger_sources,
  input  wire logic                    sleep_req,
  input  wire logic                    rc_osc,
  input  wire logic [`RES_W-1:0]       result_data,
  output logic                         converter_on,
  output logic      [5:0]              channel_select_field,
  output logic                         channel_connect,
  output logic      [1:0]              positive_reference_field,
  output logic                         conversion_busy,
  output logic                         converter_interrupt_flag
);
  ctrl_state_t s;
  ctrl_state_t next_s;
  conv_if      conv ();

  logic              wr_ctrl;
  logic              wr_cfg;
  logic              wr_trig;
  logic              wr_hi;
  logic              wr_lo;
  logic              trig_level;
  logic              trig_edge;
  logic              conv_on_next;
  logic [7:0]        read_value;
  logic [15:0]       placed;

  // ****************************************************************
  // Result placement
  // ****************************************************************
  function automatic logic [15:0] place_result(input logic fmt, input logic [`RES_W-1:0] r);
    if (fmt)
      place_result = {6'h00, r[9:8], r[7:0]};
    else
      place_result = {r[9:2], r[1:0], 6'h00};
  endfunction

  // Channel codes that reach an analog input
  function automatic logic chan_valid(input logic [5:0] c);
    chan_valid = !(c >= `CHAN_RSV_LO && c <= `CHAN_RSV_HI);
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  conv_clock_div u_div (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clk_sel (s.clk),
    .rc_osc  (rc_osc),
    .bus     (conv.divider)
  );

  conv_sequencer u_seq (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .result_data (result_data),
    .bus         (conv.seq)
  );

  // Sequencer runs while the status bit is set
  assign conv.run = s.go;

  // ****************************************************************
  // Decode and trigger edge
  // ****************************************************************
  always_comb
  begin
    wr_ctrl = reg_wr && reg_addr == `REG_CTRL;
    wr_cfg = reg_wr && reg_addr == `REG_CFG;
    wr_trig = reg_wr && reg_addr == `REG_TRIG;
    wr_hi = reg_wr && reg_addr == `REG_RES_HI;
    wr_lo = reg_wr && reg_addr == `REG_RES_LO;
    if (s.trig == `TRIG_OFF)
      trig_level = 1'b0;
    else
      trig_level = trigger_sources[s.trig - 4'h1];
    trig_edge = trig_level & ~s.trig_prev;
    placed = place_result(s.fmt, conv.result);
  end

  // Read multiplexer
  always_comb
  begin
    case (reg_addr)
      `REG_CTRL:   read_value = {s.chan, s.go, s.en};
      `REG_CFG:    read_value = {s.fmt, s.clk, 2'b00, s.pref};
      `REG_TRIG:   read_value = {4'h0, s.trig};
      `REG_RES_HI: read_value = s.res_hi;
      `REG_RES_LO: read_value = s.res_lo;
      default:     read_value = 8'h00;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_s = s;
    next_s.flag = 1'b0;
    next_s.trig_prev = trig_level;
    next_s.rdata = reg_rd ? read_value : 8'h00;
    // Configuration writes
    if (wr_ctrl)
    begin
      next_s.chan = reg_wdata[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB];
      next_s.en = reg_wdata[`CTRL_EN_BIT];
    end
    if (wr_cfg)
    begin
      next_s.fmt = reg_wdata[`CFG_FMT_BIT];
      next_s.clk = reg_wdata[`CFG_CLK_MSB:`CFG_CLK_LSB];
      next_s.pref = reg_wdata[`CFG_REF_MSB:`CFG_REF_LSB];
    end
    if (wr_trig)
      next_s.trig = reg_wdata[`TRIG_MSB:0];
    if (wr_hi)
      next_s.res_hi = reg_wdata;
    if (wr_lo)
      next_s.res_lo = reg_wdata;
    // Converter power, sleep abort keeps the enable bit
    conv_on_next = next_s.en && !(sleep_req && !is_rc(next_s.clk));
    next_s.conv_on = conv_on_next;
    next_s.mux_ok = conv_on_next && chan_valid(next_s.chan);
    // Completion loads results and pulses the flag
    if (conv.done)
    begin
      next_s.go = 1'b0;
      next_s.res_hi = placed[15:8];
      next_s.res_lo = placed[7:0];
      next_s.flag = 1'b1;
    end
    if (wr_ctrl)
      next_s.go = reg_wdata[`CTRL_GO_BIT];
    if (trig_edge)
      next_s.go = 1'b1;
    if (!conv_on_next)
      next_s.go = 1'b0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.chan <= 6'(`CTRL_RST >> `CTRL_CHAN_LSB);
      s.fmt <= 1'(`CFG_RST >> `CFG_FMT_BIT);
      s.trig <= 4'(`TRIG_RST);
      s.res_hi <= `RES_RST;
      s.res_lo <= `RES_RST;
    end
    else
      s <= next_s;
  end

  // Outputs straight from state
  assign reg_rdata = s.rdata;
  assign converter_on = s.conv_on;
  assign channel_select_field = s.chan;
  assign channel_connect = s.mux_ok;
  assign positive_reference_field = s.pref;
  assign conversion_busy = s.go;
  assign converter_interrupt_flag = s.flag;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Completion not overridden by a restart
  sequence done_seen;
    conv.done && !trig_edge && !wr_ctrl;
  endsequence

  // Rising edge of the selected trigger
  sequence trig_rise;
    s.trig != `TRIG_OFF && trig_level && !s.trig_prev;
  endsequence

  // Selected trigger held low
  sequence trig_low;
    s.trig != `TRIG_OFF && !trig_level;
  endsequence

  // Software start with the converter powered
  sequence sw_start;
    wr_ctrl && reg_wdata[`CTRL_GO_BIT] && reg_wdata[`CTRL_EN_BIT] && !sleep_req;
  endsequence

  done_clears_go_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    done_seen |=> !s.go) else $error("status bit not cleared at completion");

  done_flag_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conv.done |=> s.flag ##1 !s.flag) else $error("flag not a single pulse at completion");

  right_format_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conv.done && s.fmt |=> s.res_hi[7:2] == 6'h00 && s.res_lo == $past(conv.result[7:0]))
    else $error("right justified load wrong");

  left_format_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conv.done && !s.fmt |=> s.res_lo[5:0] == 6'h00 && s.res_hi == $past(conv.result[9:2]))
    else $error("left justified load wrong");

  trig_sets_go_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    trig_rise ##0 conv_on_next |=> s.go) else $error("trigger edge did not start conversion");

  sw_start_busy_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sw_start |=> conversion_busy)
    else $error("software start not reported busy");

  busy_held_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.go && !conv.done && !wr_ctrl && conv_on_next |=> conversion_busy)
    else $error("status bit dropped while converting");

  cfg_zero_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == `REG_CFG |=> reg_rdata[3:2] == 2'b00)
    else $error("config reserved bits read nonzero");

  trig_zero_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == `REG_TRIG |=> reg_rdata[7:4] == 4'h0)
    else $error("trigger reserved bits read nonzero");

  sleep_abort_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sleep_req && !is_rc(s.clk) && !reg_wr |=> !converter_on && !s.go && s.en == $past(s.en))
    else $error("sleep did not abort conversion");

  disabled_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !s.en |-> !converter_on && !conversion_busy) else $error("disabled converter active");

  trig_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.trig == `TRIG_OFF && !s.go && !reg_wr |=> !s.go)
    else $error("conversion started with trigger disabled");

  // Trigger low then high starts a conversion
  trig_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    trig_low ##1 (trig_level && conv_on_next) |=> conversion_busy)
    else $error("trigger low then high did not start conversion");

  // Result placement of the remaining bits
  right_high_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conv.done && s.fmt |=> s.res_hi[1:0] == $past(conv.result[9:8]))
    else $error("right justified upper bits wrong");

  left_low_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conv.done && !s.fmt |=> s.res_lo[7:6] == $past(conv.result[1:0]))
    else $error("left justified lower bits wrong");

  result_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !conv.done && !wr_hi |=> s.res_hi == $past(s.res_hi))
    else $error("result high changed without a load");

  flag_only_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !conv.done |=> !converter_interrupt_flag)
    else $error("flag raised without completion");

  // Channel and reference outputs
  reserved_chan_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    channel_select_field >= `CHAN_RSV_LO && channel_select_field <= `CHAN_RSV_HI
      |-> !channel_connect)
    else $error("reserved channel code connected");

  ref_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_cfg |=> positive_reference_field == $past(reg_wdata[`CFG_REF_MSB:`CFG_REF_LSB]))
    else $error("reference field not taken from write");

  // Status readback and power off
  ctrl_readback_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == `REG_CTRL |=> reg_rdata[`CTRL_GO_BIT] == $past(conversion_busy))
    else $error("status bit readback wrong");

  off_drops_go_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !conv_on_next |=> !conversion_busy && !converter_on)
    else $error("converter off but still busy");
endmodule // adc_control_registers
`default_nettype wire

// file: src/conv_clock_div.sv
`timescale 1ns/10ps
`default_nettype none
module conv_clock_div
  import adc_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   sys_rst,
  input  wire logic   [2:0] clk_sel,
  input  wire logic   rc_osc,
  conv_if.divider     bus
);
  div_state_t s;
  div_state_t next_s;

  // ****************************************************************
  // Conversion clock tick
  // ****************************************************************
  always_comb
  begin
    next_s = s;
    next_s.rc_meta = rc_osc;
    next_s.rc_sync = s.rc_meta;
    next_s.rc_prev = s.rc_sync;
    next_s.tick = 1'b0;
    if (!bus.run)
    begin
      next_s.count = 6'h00;
    end
    else if (is_rc(clk_sel))
    begin
      next_s.tick = s.rc_sync & ~s.rc_prev;
    end
    else if (s.count >= div_limit(clk_sel))
    begin
      next_s.count = 6'h00;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.count = s.count + 6'h01;
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign bus.tick = s.tick;

  tick_single_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.tick |=> !s.tick) else $error("conversion tick longer than one cycle");
endmodule // conv_clock_div
`default_nettype wire

// file: src/conv_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg.svh"
module conv_sequencer
  import adc_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   sys_rst,
  input  wire logic   [`RES_W-1:0] result_data,
  conv_if.seq         bus
);
  seq_state_t s;
  seq_state_t next_s;

  // ****************************************************************
  // Conversion sequence
  // ****************************************************************
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.mode)
      SEQ_IDLE:
      begin
        if (bus.run && !s.done)
        begin
          next_s.mode = SEQ_RUN;
          next_s.count = 4'h0;
        end
      end
      SEQ_RUN:
      begin
        if (!bus.run)
          next_s.mode = SEQ_IDLE;
        else if (bus.tick && s.count == `CONV_LAST)
        begin
          next_s.mode = SEQ_IDLE;
          next_s.done = 1'b1;
          next_s.result = result_data;
        end
        else if (bus.tick)
          next_s.count = s.count + 4'h1;
      end
      default:
      begin
        next_s = '0;
        next_s.mode = SEQ_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.mode <= SEQ_IDLE;
    end
    else
      s <= next_s;
  end

  assign bus.done = s.done;
  assign bus.result = s.result;

  done_after_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.done |-> $past(s.count) == `CONV_LAST && $past(s.mode) == SEQ_RUN)
    else $error("conversion ended before its last tick");
endmodule // conv_sequencer
`default_nettype wire

// file: verification/adc_control_registers_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg.svh"
module adc_control_registers_tb
  import adc_pkg::*;
;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic                   sys_clk;
  logic                   sys_rst;
  logic [`ADDR_W-1:0]     reg_addr;
  logic [7:0]             reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [7:0]             reg_rdata;
  logic [`TRIG_SRC_N-1:0] trigger_sources;
  logic                   sleep_req;
  logic                   rc_osc;
  logic                   rc_run;
  logic [`RES_W-1:0]      result_data;
  logic                   converter_on;
  logic [5:0]             channel_select_field;
  logic                   channel_connect;
  logic [1:0]             positive_reference_field;
  logic                   conversion_busy;
  logic                   converter_interrupt_flag;
  int                     failures;
  int                     num_checks;
  int                     cycles;
  int                     n;
  logic [2:0]             codes [8];
  int                     divs [8];

  adc_control_registers adc_control_registers_i (
    .sys_clk                  (sys_clk),
    .sys_rst                  (sys_rst),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .trigger_sources          (trigger_sources),
    .sleep_req                (sleep_req),
    .rc_osc                   (rc_osc),
    .result_data              (result_data),
    .converter_on             (converter_on),
    .channel_select_field     (channel_select_field),
    .channel_connect          (channel_connect),
    .positive_reference_field (positive_reference_field),
    .conversion_busy          (conversion_busy),
    .converter_interrupt_flag (converter_interrupt_flag)
  );

  // ****************************************************************
  // Clocks and hang guard
  // ****************************************************************
  // System clock, 100 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // RC clock, unrelated in phase, runs only when enabled
  initial
  begin
    rc_osc = 1'b0;
    forever #285 rc_osc = rc_run ? ~rc_osc : 1'b0;
  end

  // Cycle ceiling well above the expected run length
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures = failures + 1;
      summarize();
    end
  end

  // ****************************************************************
  // Helper tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Waits for the completion pulse and checks its timing
  task automatic finish_conv(input int lo, input int hi);
    n = 0;
    while (converter_interrupt_flag !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk);
      #1;
      n = n + 1;
    end
    check(conversion_busy, 1'b0);
    check(n >= lo && n <= hi, 1'b1);
    idle(1);
    check(converter_interrupt_flag, 1'b0);
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    failures        = 0;
    num_checks      = 0;
    cycles          = 0;
    sys_rst         = 1'b1;
    reg_addr        = 3'h0;
    reg_wdata       = 8'h00;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    trigger_sources = 15'h0000;
    sleep_req       = 1'b0;
    rc_run          = 1'b0;
    result_data     = 10'h000;
    codes = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
    divs  = '{2, 8, 32, 4, 16, 64, 6, 6};
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;

    // Reset values and an unmapped index
    for (int a = 0; a < 6; a++)
      rd(a[2:0], 8'h00);
    check(converter_on, 1'b0);

    // Unimplemented bits read zero, reference code reaches the port
    wr(`REG_CFG, 8'hFF);
    rd(`REG_CFG, 8'hF3);
    check(positive_reference_field, 2'h3);
    wr(`REG_TRIG, 8'hFF);
    rd(`REG_TRIG, 8'h0F);
    wr(`REG_TRIG, 8'h00);
    wr(5, 8'hFF);
    rd(5, 8'h00);

    // Channel codes: port A, reserved, port C
    wr(`REG_CTRL, {6'h05, 2'b01});
    idle(2);
    check(channel_connect, 1'b1);
    check(converter_on, 1'b1);
    wr(`REG_CTRL, {6'h06, 2'b01});
    idle(2);
    check(channel_connect, 1'b0);
    wr(`REG_CTRL, {6'h17, 2'b01});
    idle(2);
    check(channel_select_field, 6'h17);
    check(channel_connect, 1'b1);

    // Every clock code, right justified results
    for (int i = 0; i < 8; i++)
    begin
      rc_run      = (i >= 6);
      @(posedge sys_clk);
      result_data <= 10'h2A5 ^ {7'h00, codes[i]};
      wr(`REG_CFG, {1'b1, codes[i], 4'h2});
      wr(`REG_CTRL, {6'h10, 2'b11});
      #1;
      check(conversion_busy, 1'b1);
      rd(`REG_CTRL, {6'h10, 2'b11});
      if (i >= 6)
        finish_conv(50, 90);
      else
        finish_conv(10 * divs[i], 12 * divs[i] + 6);
      rd(`REG_CTRL, {6'h10, 2'b01});
      rd(`REG_RES_HI, {6'h00, 2'b10});
      rd(`REG_RES_LO, 8'hA5 ^ {5'h00, codes[i]});
    end
    rc_run = 1'b0;

    // Left justified result
    @(posedge sys_clk);
    result_data <= 10'h2A5;
    wr(`REG_CFG, 8'h00);
    wr(`REG_CTRL, {6'h10, 2'b11});
    finish_conv(20, 30);
    rd(`REG_RES_HI, 8'hA9);
    rd(`REG_RES_LO, 8'h40);

    // Rising edge on the selected source starts a conversion
    wr(`REG_TRIG, 8'h03);
    idle(2);
    @(posedge sys_clk);
    trigger_sources <= 15'h0004;
    idle(3);
    check(conversion_busy, 1'b1);
    finish_conv(15, 30);
    @(posedge sys_clk);
    trigger_sources <= 15'h0000;
    idle(2);
    check(conversion_busy, 1'b0);

    // Trigger value zero ignores edges
    wr(`REG_TRIG, 8'h00);
    idle(2);
    @(posedge sys_clk);
    trigger_sources <= 15'h7FFF;
    idle(4);
    check(conversion_busy, 1'b0);
    @(posedge sys_clk);
    trigger_sources <= 15'h0000;

    // Sleep aborts a system clock conversion, enable stays set
    wr(`REG_CFG, 8'h60);
    wr(`REG_CTRL, {6'h10, 2'b11});
    idle(10);
    @(posedge sys_clk);
    sleep_req <= 1'b1;
    idle(3);
    check(converter_on, 1'b0);
    check(conversion_busy, 1'b0);
    rd(`REG_CTRL, {6'h10, 2'b01});
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    idle(3);
    check(converter_on, 1'b1);

    // Clearing enable turns the converter off
    wr(`REG_CTRL, {6'h10, 2'b00});
    idle(2);
    check(converter_on, 1'b0);
    check(channel_connect, 1'b0);
    summarize();
  end
endmodule // adc_control_registers_tb
`default_nettype wire
